/* hw/ecc_sram_host.sv */
/*
 Host controller that drives an asynchronous ECC static memory through its
 pins: one request at a time, one response pulse per finished access.
 Assumes memory inputs are synchronous to clk and a tristate wire built
 outside from data_out and data_oe.
*/
// Function
// - write needs strobe, select, lane overlap
// - time data to the ending rising edge
// - never drive data while memory drives
// - strobe stays high for every read
// - address valid by select falling edge
// - strobe pulse covers setup plus float
// - wait recovery time after data retention
`timescale 1ns/1ps
`default_nettype none
module ecc_sram_host
(
   input  wire  logic                         clk,
   input  wire  logic                         rst_n,
   input  wire  logic                         req_valid,
   output logic                               req_ready,
   input  wire  sram_port_pkg::req_t          req,
   output logic                               rsp_valid,
   output sram_port_pkg::rsp_t                rsp,
   input  wire  logic                         retention,
   input  wire  logic                         supply_hi,
   output sram_port_pkg::pin_ctl_t            ctl,
   output logic [sram_port_pkg::ADDR_W-1:0]   addr,
   output logic [sram_port_pkg::DATA_W-1:0]   data_out,
   output logic                               data_oe,
   input  wire  logic [sram_port_pkg::DATA_W-1:0] data_in,
   input  wire  logic                         fixed_flag_in
);
   import sram_port_pkg::*;

   // ==========================================================
   // State
   state_t              state_r, state_nxt;   // Access sequencer
   logic [CNT_W-1:0]    cnt_r, cnt_nxt;       // Cycles left in a wait
   pin_ctl_t            ctl_r, ctl_nxt;       // Control pins
   logic [ADDR_W-1:0]   addr_r, addr_nxt;     // Address pins
   logic [DATA_W-1:0]   dout_r, dout_nxt;     // Write data
   logic                doe_r, doe_nxt;       // Host drives data
   rsp_t                rsp_r, rsp_nxt;       // Last answer
   logic                rv_r, rv_nxt;         // Answer pulse
   logic [1:0]          lanes;                // Lanes of the request

   // No lane asked means both, so a write always gets its overlap
   assign lanes = (|req.lane_en) ? req.lane_en : 2'h3;

   // Ready only when idle and the supply is not in retention
   assign req_ready = (state_r == S_IDLE) && !retention;
   assign ctl       = ctl_r;
   assign addr      = addr_r;
   assign data_out  = dout_r;
   assign data_oe   = doe_r;
   assign rsp       = rsp_r;
   assign rsp_valid = rv_r;

   // ==========================================================
   // Next-state logic
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      ctl_nxt   = ctl_r;
      addr_nxt  = addr_r;
      dout_nxt  = dout_r;
      doe_nxt   = doe_r;
      rsp_nxt   = rsp_r;
      rv_nxt    = 1'b0;
      unique case (state_r)
         S_IDLE:
         begin
            // Retention first: no access until recovery has run
            if (retention)
            begin
               state_nxt = S_REC;
               cnt_nxt   = CNT_W'(supply_hi ? REC_HI_CYC : REC_LO_CYC);
            end
            else if (req_valid)
            begin
               // Address goes out with the select edge itself
               addr_nxt                 = req.addr;
               ctl_nxt.select_primary_n = 1'b0;
               ctl_nxt.select_secondary = 1'b1;
               ctl_nxt.low_byte_sel_n   = !lanes[0];
               ctl_nxt.high_byte_sel_n  = !lanes[1];
               if (req.write)
               begin
                  // Output drive stays high so the memory floats
                  dout_nxt  = req.wdata;
                  doe_nxt   = 1'b1;
                  state_nxt = S_WR_SET;
               end
               else
               begin
                  // Strobe stays high for the whole read
                  ctl_nxt.output_drive_n = 1'b0;
                  cnt_nxt   = CNT_W'(RD_CYC);
                  state_nxt = S_RD;
               end
            end
         end
         S_REC:
         begin
            // Reload while retention persists, then count down
            if (retention)
               cnt_nxt = CNT_W'(supply_hi ? REC_HI_CYC : REC_LO_CYC);
            else if (cnt_r <= 4'h1)
               state_nxt = S_IDLE;
            else
               cnt_nxt = cnt_r - 4'h1;
         end
         S_WR_SET:
         begin
            // Setup cycle done: open the overlap with the strobe
            ctl_nxt.write_strobe_n = 1'b0;
            cnt_nxt   = CNT_W'(PULSE_CYC);
            state_nxt = S_WR_PULSE;
         end
         S_WR_PULSE:
         begin
            // The strobe rise is the terminating edge
            if (cnt_r <= 4'h1)
            begin
               ctl_nxt.write_strobe_n = 1'b1;
               state_nxt = S_WR_END;
            end
            else
               cnt_nxt = cnt_r - 4'h1;
         end
         S_WR_END:
         begin
            // Data and address held one cycle past the strobe rise
            ctl_nxt   = CTL_IDLE;
            doe_nxt   = 1'b0;
            rsp_nxt   = '0;
            rv_nxt    = 1'b1;
            state_nxt = S_IDLE;
         end
         S_RD:
         begin
            if (cnt_r <= 4'h1)
            begin
               // Data and flag sampled together; floated lane masked
               rsp_nxt.rdata[15:8] = ctl_r.high_byte_sel_n ? 8'h00 : data_in[15:8];
               rsp_nxt.rdata[7:0]  = ctl_r.low_byte_sel_n ? 8'h00 : data_in[7:0];
               rsp_nxt.fixed       = fixed_flag_in;
               // Report only: corrected word is never rewritten
               rv_nxt    = 1'b1;
               ctl_nxt   = CTL_IDLE;
               cnt_nxt   = CNT_W'(TURN_CYC);
               state_nxt = S_TURN;
            end
            else
               cnt_nxt = cnt_r - 4'h1;
         end
         S_TURN:
         begin
            // Let the memory float before the host may drive
            if (cnt_r <= 4'h1)
               state_nxt = S_IDLE;
            else
               cnt_nxt = cnt_r - 4'h1;
         end
      endcase
   end

   // ==========================================================
   // Registers, synchronous reset to a deselected bus
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_r <= S_IDLE;
         cnt_r   <= '0;
         ctl_r   <= CTL_IDLE;
         addr_r  <= '0;
         dout_r  <= '0;
         doe_r   <= 1'b0;
         rsp_r   <= '0;
         rv_r    <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         ctl_r   <= ctl_nxt;
         addr_r  <= addr_nxt;
         dout_r  <= dout_nxt;
         doe_r   <= doe_nxt;
         rsp_r   <= rsp_nxt;
         rv_r    <= rv_nxt;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_select_pair: assert property (ctl.select_primary_n == !ctl.select_secondary)
      else $error("select pins disagree");
   chk_write_overlap: assert property (!ctl.write_strobe_n |-> !ctl.select_primary_n
      && (!ctl.low_byte_sel_n || !ctl.high_byte_sel_n) && data_oe)
      else $error("strobe low without overlap");
   chk_data_hold: assert property ($rose(ctl.write_strobe_n) |-> data_oe
      && $stable(data_out) && $stable(addr))
      else $error("data moved at write end");
   chk_no_clash: assert property (data_oe |-> ctl.output_drive_n)
      else $error("host drives while memory may drive");
   chk_turn_gap: assert property ($rose(ctl.output_drive_n) |-> !data_oe [*2])
      else $error("no float gap after read");
   chk_read_strobe: assert property (!ctl.output_drive_n |-> ctl.write_strobe_n)
      else $error("strobe low during read");
   chk_addr_stable: assert property (!ctl.select_primary_n && !$past(ctl.select_primary_n)
      |-> $stable(addr))
      else $error("address moved while selected");
   chk_read_answer: assert property ($fell(ctl.output_drive_n) |=> rsp_valid
      && ctl.output_drive_n)
      else $error("read answer late");
   chk_pulse_len: assert property ($fell(ctl.write_strobe_n) |=> $rose(ctl.write_strobe_n))
      else $error("strobe pulse length wrong");
   chk_recovery: assert property ($fell(retention) |-> !req_ready)
      else $error("ready without recovery");

   cov_read:  cover property ($fell(ctl.output_drive_n) ##1 rsp_valid);
   cov_write: cover property ($fell(ctl.write_strobe_n) ##2 rsp_valid);
   cov_fixed: cover property (rsp_valid && rsp.fixed);
   cov_rec:   cover property ($fell(retention) ##[1:4] req_ready);

endmodule
`default_nettype wire

/* hw/sram_port_pkg.sv */
/*
 Constants, timing counts and carrier types for the host-side controller
 of an asynchronous 16-bit static memory with built-in error correction.
 Assumes a single 50 MHz clock and the slowest speed grade of the memory.
*/
package sram_port_pkg;

   // ==========================================================
   // Widths
   localparam int ADDR_W = 18;        // Word address width
   localparam int DATA_W = 16;        // Two byte lanes
   localparam int CNT_W  = 4;         // Wait counter width

   // ==========================================================
   // Times in ns, worst speed grade
   localparam int CLK_NS    = 20;     // 50 MHz clock period
   localparam int T_AA_NS   = 15;     // Address / flag access
   localparam int T_PWE_NS  = 12;     // Least strobe pulse
   localparam int T_SD_NS   = 8;      // Data setup to write end
   localparam int T_HZWE_NS = 8;      // Strobe low to float
   localparam int T_HZOE_NS = 8;      // Output drive high to float
   localparam int T_R_HI_NS = 10;     // Recovery, supply at or above 2.2 V
   localparam int T_R_LO_NS = 15;     // Recovery, supply below 2.2 V

   // Least time to whole cycles, rounding up, never below one
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int RD_CYC     = cyc_up(T_AA_NS);
   localparam int PWE_CYC    = cyc_up(T_PWE_NS);
   localparam int SDHZ_CYC   = cyc_up(T_SD_NS + T_HZWE_NS);
   localparam int PULSE_CYC  = (PWE_CYC > SDHZ_CYC) ? PWE_CYC : SDHZ_CYC;
   localparam int TURN_CYC   = cyc_up(T_HZOE_NS);
   localparam int REC_HI_CYC = cyc_up(T_R_HI_NS);
   localparam int REC_LO_CYC = cyc_up(T_R_LO_NS);

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic select_primary_n;         // Select, active low
      logic select_secondary;         // Select, active high
      logic output_drive_n;           // Memory drives data when low
      logic write_strobe_n;           // Write strobe
      logic low_byte_sel_n;           // Lane 7:0
      logic high_byte_sel_n;          // Lane 15:8
   } pin_ctl_t;

   // Deselected, all strobes idle
   localparam pin_ctl_t CTL_IDLE = 6'h2F;

   typedef struct packed {
      logic              write;       // 1 write, 0 read
      logic [1:0]        lane_en;     // Bit 1 upper, bit 0 lower
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } req_t;

   typedef struct packed {
      logic [DATA_W-1:0] rdata;       // Unselected lane reads zero
      logic              fixed;       // Single-bit error corrected
   } rsp_t;

   typedef enum logic [2:0] {
      S_IDLE, S_REC, S_WR_SET, S_WR_PULSE, S_WR_END, S_RD, S_TURN
   } state_t;

endpackage

/* dv/ecc_sram_model.sv */
/*
 Pin-level model of the ECC static memory facing the host controller.
 Assumes pins change just after rising clk edges; 16 words, low nibble.
*/
`timescale 1ns/1ps
`default_nettype none
module ecc_sram_model
(
   input  wire logic                             clk,
   input  wire sram_port_pkg::pin_ctl_t          ctl,
   input  wire logic [sram_port_pkg::ADDR_W-1:0] addr,
   input  wire logic [15:0]                      data_out,
   input  wire logic                             data_oe,
   input  wire logic                             inj_en,
   input  wire logic [3:0]                       inj_addr,
   output logic [15:0]                           data_in,
   output logic                                  fixed_flag_in,
   output var int                                clash_cnt
);
   import sram_port_pkg::*;
   logic [15:0] mem [16];   // Stored words, kept corrected
   logic [15:0] bad;        // Word holds a single-bit fault
   logic [15:0] last_r;     // Pin value one cycle ago
   logic        last_f;     // Flag pin one cycle ago
   logic        sel;        // Combined select
   logic        rd;         // Read mode
   logic [1:0]  lane;       // Lanes driven, bit 1 upper
   logic [3:0]  a;          // Word index
   // ==========================================
   // Decode
   assign a = addr[3:0];
   assign sel = !ctl.select_primary_n && ctl.select_secondary;
   assign rd = sel && !ctl.output_drive_n && ctl.write_strobe_n;
   assign lane = rd ? ~{ctl.high_byte_sel_n, ctl.low_byte_sel_n} : 2'b00;
   // Floating pins invert their last value, so a stale sample is caught
   always_comb
   begin
      data_in[7:0] = lane[0] ? mem[a][7:0] : ~last_r[7:0];
      data_in[15:8] = lane[1] ? mem[a][15:8] : ~last_r[15:8];
      fixed_flag_in = (|lane) ? bad[a] : ~last_f;
   end
   // ==========================================
   // Array: stores only during the full overlap; reads never write back
   always @(posedge clk)
   begin
      last_r <= data_in;
      last_f <= fixed_flag_in;
      if (data_oe && |lane) clash_cnt <= clash_cnt + 1;
      if (sel && !ctl.write_strobe_n && !ctl.low_byte_sel_n) mem[a][7:0] <= data_out[7:0];
      if (sel && !ctl.write_strobe_n && !ctl.high_byte_sel_n) mem[a][15:8] <= data_out[15:8];
      if (sel && !ctl.write_strobe_n) bad[a] <= 1'b0;
      if (inj_en) bad[inj_addr] <= 1'b1;
   end
   initial
   begin
      clash_cnt = 0;
      bad = '0;
      last_r = '0;
      last_f = 1'b0;
      foreach (mem[i]) mem[i] = '0;
   end
endmodule
`default_nettype wire

/* dv/test_ecc_sram_host.sv */
/*
 Self-checking bench for the ECC static memory host controller.
 Assumes the pin model in ecc_sram_model.sv stands at the far side.
*/
`timescale 1ns/1ps
`default_nettype none
module test_ecc_sram_host;
   import sram_port_pkg::*;
   logic        clk, rst_n, req_valid, retention, supply_hi, inj_en;
   logic        req_ready, rsp_valid, data_oe, fixed_flag_in;
   req_t        req;
   rsp_t        rsp, got;
   pin_ctl_t    ctl;
   logic [17:0] addr;
   logic [15:0] data_out, data_in;
   logic [3:0]  inj_addr;
   int          error_cnt, checked, cyc, clash_cnt, lat;
   ecc_sram_host ecc_sram_host_i (.clk, .rst_n, .req_valid, .req_ready, .req, .rsp_valid,
      .rsp, .retention, .supply_hi, .ctl, .addr, .data_out, .data_oe, .data_in, .fixed_flag_in);
   ecc_sram_model ecc_sram_model_i (.clk, .ctl, .addr, .data_out, .data_oe, .inj_en,
      .inj_addr, .data_in, .fixed_flag_in, .clash_cnt);
   // ==========================================
   // Clock and hang guard
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         error_cnt++;
         end_sim();
      end
   end
   // ==========================================
   // Shared tasks
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One access, held until taken; leaves at a rising edge
   task automatic access(logic wr, logic [1:0] ln, logic [3:0] a, logic [15:0] d);
      int n;
      req <= '{wr, ln, {14'h2A5C, a}, d};
      req_valid <= 1'b1;
      n = 0;
      do @(negedge clk); while (!req_ready && ++n < 50);
      @(posedge clk);
      req_valid <= 1'b0;
      lat = 0;
      // Answer read just after the edge that launches it
      do
      begin
         @(posedge clk);
         lat++;
         #1;
      end
      while (!rsp_valid && lat < 20);
      got = rsp;
      check("latency", lat, wr ? PULSE_CYC + 2 : RD_CYC);
      // Write answers carry no data and no flag
      if (wr)
         check("write answer", got, 32'h00000000);
      @(posedge clk);
   endtask
   task automatic rd_chk(logic [1:0] ln, logic [3:0] a, logic [15:0] d, logic f);
      access(1'b0, ln, a, 16'h0000);
      check("rdata", got.rdata, d);
      check("fixed", got.fixed, f);
   endtask
   task automatic t_retain(logic hi);
      int n;
      retention <= 1'b1;
      supply_hi <= hi;
      repeat (3) @(posedge clk);
      check("ready in retention", req_ready, 1'b0);
      retention <= 1'b0;
      @(negedge clk);
      check("ready at recovery", req_ready, 1'b0);
      n = 0;
      while (!req_ready && n < 8)
      begin
         @(negedge clk);
         n++;
      end
      check("recovered", req_ready, 1'b1);
      check("recovery cycles", n, hi ? REC_HI_CYC : REC_LO_CYC);
      @(posedge clk);
      $display("retention test done");
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ==========================================
   // Main sequence
   initial
   begin
      {rst_n, req_valid, retention, supply_hi, inj_en} = 5'h00;
      req = '0;
      inj_addr = 4'h0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check("idle pins", ctl, CTL_IDLE);
      check("idle drive", data_oe, 1'b0);
      $display("reset test done");
      access(1'b1, 2'b00, 4'h5, 16'hA5C3);
      rd_chk(2'b00, 4'h5, 16'hA5C3, 1'b0);
      access(1'b1, 2'b11, 4'h3, 16'h1111);
      access(1'b1, 2'b01, 4'h3, 16'h22EE);
      access(1'b1, 2'b10, 4'h3, 16'h7733);
      rd_chk(2'b01, 4'h3, 16'h00EE, 1'b0);
      rd_chk(2'b10, 4'h3, 16'h7700, 1'b0);
      rd_chk(2'b11, 4'h3, 16'h77EE, 1'b0);
      $display("lane test done");
      access(1'b1, 2'b11, 4'h6, 16'hBEEF);
      inj_en <= 1'b1;
      inj_addr <= 4'h6;
      @(posedge clk);
      inj_en <= 1'b0;
      rd_chk(2'b11, 4'h6, 16'hBEEF, 1'b1);
      rd_chk(2'b01, 4'h6, 16'h00EF, 1'b1);
      access(1'b1, 2'b11, 4'h6, 16'h0F0F);
      rd_chk(2'b11, 4'h6, 16'h0F0F, 1'b0);
      $display("correction test done");
      t_retain(1'b1);
      t_retain(1'b0);
      rd_chk(2'b11, 4'h5, 16'hA5C3, 1'b0);
      check("contention", clash_cnt, 0);
      end_sim();
   end
endmodule
`default_nettype wire
